// [core/dao_ctrl_end.sv]
// Controller end: CKE sequencing, command gating and RTT-uncertain windows
`timescale 1ns/1ps
`default_nettype none
module dao_ctrl_end
	import dao_pkg::*;
#(
	parameter int unsigned CNT_W      = DAO_CNT_W,
	parameter int unsigned TRFC_CYC   = DAO_TRFC_CYC,
	parameter int unsigned TXPDLL_CYC = DAO_TXPDLL_CYC,
	parameter int unsigned TCPDED_CYC = DAO_TCPDED_CK
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic [DAO_WL_W-1:0] wl,
	input  wire logic                mr0_pd_dll,
	input  wire logic                pd_req,
	input  wire logic                cmd_valid,
	input  wire dao_cmd_t            cmd_code,
	input  wire logic                odt_req,
	dao_link_if.ctrl                 link,
	output logic                     cmd_ready,
	output logic                     cmd_reject,
	output logic                     in_pd,
	output logic                     entry_win,
	output logic                     exit_win,
	output logic                     rtt_uncertain
);
	typedef enum logic [1:0] {
		DAO_ST_UP,
		DAO_ST_ENTRY_LEAD,
		DAO_ST_PD,
		DAO_ST_EXIT_LEAD
	} dao_state_t;

	dao_state_t          state_q;
	dao_state_t          state_d;
	logic [DAO_WL_W-1:0] lead_q;
	logic [DAO_WL_W-1:0] lead_d;
	logic [DAO_WL_W-1:0] lead_len;
	logic [CNT_W-1:0]    ent_q;
	logic [CNT_W-1:0]    ent_d;
	logic [CNT_W-1:0]    ext_q;
	logic [CNT_W-1:0]    ext_d;
	logic [CNT_W-1:0]    trfc_q;
	logic [CNT_W-1:0]    trfc_d;
	logic                fire;
	logic                frozen;
	logic                entry_d;
	logic                exit_d;
	logic                cke_d;

	function automatic logic [CNT_W-1:0] cnt_max(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
		cnt_max = (a > b) ? a : b;
	endfunction

	assign frozen   = (mr0_pd_dll == DAO_PD_DLL_FROZEN);
	assign lead_len = (wl > DAO_WL_W'(DAO_TANPD_OFS)) ? wl - DAO_WL_W'(DAO_TANPD_OFS) : DAO_WL_W'(1);
	assign fire     = cmd_valid && cmd_ready;

	always_comb begin
		state_d = state_q;
		lead_d  = lead_q;
		ent_d   = (ent_q != '0) ? ent_q - 1'b1 : '0;
		ext_d   = (ext_q != '0) ? ext_q - 1'b1 : '0;
		trfc_d  = (trfc_q != '0) ? trfc_q - 1'b1 : '0;
		if (fire && cmd_code == DAO_CMD_REF) begin
			trfc_d = CNT_W'(TRFC_CYC);
		end
		case (state_q)
			DAO_ST_UP: begin
				// A command issued this cycle wins; entry starts next cycle
				if (pd_req && !fire) begin
					state_d = DAO_ST_ENTRY_LEAD;
					lead_d  = lead_len;
				end
			end
			DAO_ST_ENTRY_LEAD: begin
				if (lead_q <= DAO_WL_W'(1)) begin
					state_d = DAO_ST_PD;
					// Refresh still running pushes the end out to tRFC
					ent_d   = cnt_max(CNT_W'(TCPDED_CYC), trfc_d);
				end else begin
					lead_d = lead_q - 1'b1;
				end
			end
			DAO_ST_PD: begin
				// Exit may start while the entry tail still runs
				if (!pd_req) begin
					state_d = DAO_ST_EXIT_LEAD;
					lead_d  = lead_len;
				end
			end
			DAO_ST_EXIT_LEAD: begin
				if (lead_q <= DAO_WL_W'(1)) begin
					state_d = DAO_ST_UP;
					ext_d   = CNT_W'(TXPDLL_CYC + 1);
				end else begin
					lead_d = lead_q - 1'b1;
				end
			end
			default: begin
				state_d = DAO_ST_UP;
				lead_d  = '0;
			end
		endcase
	end

	// First lead cycle is the tANPD start point and stays outside
	assign entry_d = frozen && ((state_d == DAO_ST_ENTRY_LEAD && lead_d != lead_len) || ent_d != '0);
	assign exit_d  = frozen && ((state_d == DAO_ST_EXIT_LEAD && lead_d != lead_len) || ext_d != '0);
	assign cke_d   = (state_d == DAO_ST_UP || state_d == DAO_ST_ENTRY_LEAD);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= DAO_ST_UP;
			lead_q  <= '0;
		end else begin
			state_q <= state_d;
			lead_q  <= lead_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ent_q  <= '0;
			ext_q  <= '0;
			trfc_q <= '0;
		end else begin
			ent_q  <= ent_d;
			ext_q  <= ext_d;
			trfc_q <= trfc_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link.cke <= DAO_CKE_RST;
			in_pd    <= 1'b0;
		end else begin
			link.cke <= cke_d;
			in_pd    <= !cke_d;
		end
	end

	// ODT follows the user in every state; its receiver stays live in power-down
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link.odt <= DAO_ODT_RST;
		end else begin
			link.odt <= odt_req;
		end
	end

	// No commands during lead, power-down, DLL relock or refresh
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ready <= 1'b0;
		end else begin
			cmd_ready <= state_d == DAO_ST_UP && !pd_req && ext_d == '0 && trfc_d == '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link.cmd   <= DAO_CMD_NOP;
			cmd_reject <= 1'b0;
		end else begin
			link.cmd   <= fire ? cmd_code : DAO_CMD_NOP;
			cmd_reject <= cmd_valid && !cmd_ready;
		end
	end

	// Union of windows covers both overlap cases without extra logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			entry_win     <= 1'b0;
			exit_win      <= 1'b0;
			rtt_uncertain <= 1'b0;
		end else begin
			entry_win     <= entry_d;
			exit_win      <= exit_d;
			rtt_uncertain <= entry_d || exit_d;
		end
	end
endmodule
`default_nettype wire

// [core/dao_dram_end.sv]
// Memory end: ODT mode selection and termination timing around power-down
`timescale 1ns/1ps
`default_nettype none
module dao_dram_end
	import dao_pkg::*;
#(
	parameter int unsigned CNT_W      = DAO_CNT_W,
	parameter int unsigned HIST_D     = DAO_HIST_D,
	parameter int unsigned TXPDLL_CYC = DAO_TXPDLL_CYC
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic [DAO_WL_W-1:0] wl,
	input  wire logic                mr0_pd_dll,
	dao_link_if.dram                 link,
	output logic                     rtt_on,
	output logic                     async_mode,
	output logic                     in_pd,
	output logic                     rw_in_pd_err
);
	logic [HIST_D-1:0]   hist_q;
	logic [HIST_D:0]     odt_tap;
	logic [CNT_W-1:0]    xp_q;
	logic                frozen;
	logic                async_d;
	logic [DAO_WL_W-1:0] sync_idx;

	assign frozen  = (mr0_pd_dll == DAO_PD_DLL_FROZEN);
	assign odt_tap = {hist_q, link.odt};
	// Sync latency is WL-2 counting the output flop; WL below 3 clamps
	assign sync_idx = (wl > DAO_WL_W'(DAO_ODTL_OFS)) ? wl - DAO_WL_W'(DAO_ODTL_OFS + 1) : '0;
	// With DLL frozen, async from first CKE low through tXPDLL after CKE high; sync otherwise
	// In_pd bridges the reload cycle so the path select cannot blip to sync
	assign async_d = frozen && (!link.cke || in_pd || xp_q != '0);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hist_q <= '0;
		end else begin
			hist_q <= odt_tap[HIST_D-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xp_q <= '0;
		end else if (link.cke && in_pd) begin
			xp_q <= CNT_W'(TXPDLL_CYC);
		end else if (xp_q != '0) begin
			xp_q <= xp_q - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_pd      <= 1'b0;
			async_mode <= 1'b0;
		end else begin
			in_pd      <= !link.cke;
			async_mode <= async_d;
		end
	end

	// Async path ignores AL; inside a window either path is legal
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rtt_on <= DAO_ODT_RST;
		end else if (async_d) begin
			rtt_on <= odt_tap[DAO_TAPD_MIN_CYC-1];
		end else begin
			rtt_on <= odt_tap[sync_idx];
		end
	end

	// Command receivers may be off; flag any read or write seen in power-down
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rw_in_pd_err <= 1'b0;
		end else begin
			rw_in_pd_err <= !link.cke && (link.cmd == DAO_CMD_RD || link.cmd == DAO_CMD_WR);
		end
	end
endmodule
`default_nettype wire

// [core/dao_link_if.sv]
// Link between controller end and memory end: CKE, ODT and command
`timescale 1ns/1ps
`default_nettype none
interface dao_link_if;
	import dao_pkg::*;
	logic     cke;
	logic     odt;
	dao_cmd_t cmd;

	modport ctrl (output cke, output odt, output cmd);
	modport dram (input cke, input odt, input cmd);
endinterface
`default_nettype wire

// [core/dao_pkg.sv]
// Shared constants and types for the asynchronous ODT transition logic
// How it works
// - Power-down keeps ODT live; no read/write
// - DLL frozen in power-down selects async ODT
// - Async ODT path skips additive latency
// - Entry window only when DLL frozen
// - Entry window starts WL-1 before CKE low
// - Entry window ends at tCPDED end
// - Refresh in progress stretches entry to tRFC
// - Start cycle excluded, final cycle included
// - Turn-on may fall between both delays
// - Turn-off may fall between both delays
// - Before entry sync, after entry async
// - Exit window WL-1 before to tXPDLL after
// - Before exit async, after exit sync
// - Entry/exit overlap merges into one span
// - Exit/entry overlap merges into one span
package dao_pkg;
	localparam int unsigned DAO_CLK_PS      = 4000;
	localparam int unsigned DAO_WL_W        = 5;
	localparam int unsigned DAO_CNT_W       = 8;
	localparam int unsigned DAO_HIST_D      = 24;
	localparam int unsigned DAO_TANPD_OFS   = 1;
	localparam int unsigned DAO_ODTL_OFS    = 2;
	localparam int unsigned DAO_TAPD_MIN_PS = 2000;
	localparam int unsigned DAO_TAPD_MAX_PS = 8500;
	localparam int unsigned DAO_TAPD_MIN_CYC =
		(DAO_TAPD_MIN_PS + DAO_CLK_PS - 1) / DAO_CLK_PS < 1 ? 1 : (DAO_TAPD_MIN_PS + DAO_CLK_PS - 1) / DAO_CLK_PS;
	localparam int unsigned DAO_TAPD_MAX_CYC =
		DAO_TAPD_MAX_PS / DAO_CLK_PS < 1 ? 1 : DAO_TAPD_MAX_PS / DAO_CLK_PS;
	localparam int unsigned DAO_TRFC_NS     = 110;
	localparam int unsigned DAO_TXPDLL_NS   = 24;
	localparam int unsigned DAO_TCPDED_CK   = 1;
	localparam int unsigned DAO_TRFC_CYC    = (DAO_TRFC_NS * 1000 + DAO_CLK_PS - 1) / DAO_CLK_PS;
	localparam int unsigned DAO_TXPDLL_CYC  = (DAO_TXPDLL_NS * 1000 + DAO_CLK_PS - 1) / DAO_CLK_PS;
	localparam logic        DAO_CKE_RST     = 1'h1;
	localparam logic        DAO_ODT_RST     = 1'h0;
	localparam logic        DAO_PD_DLL_FROZEN = 1'h0;

	typedef enum logic [1:0] {
		DAO_CMD_NOP,
		DAO_CMD_REF,
		DAO_CMD_RD,
		DAO_CMD_WR
	} dao_cmd_t;
endpackage

// [sim/dao_checker.sv]
// Link-side timing checks for power-down and command flow
`timescale 1ns/1ps
`default_nettype none
module dao_checker
	import dao_pkg::*;
(
	input wire logic     clk,
	input wire logic     rst_n,
	input wire logic     cke,
	input wire logic     odt,
	input wire dao_cmd_t cmd
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Counts fit the bench: WL 5, tRFC 12, tXPDLL 3
	a_no_rw_pd: assert property (!cke |-> !(cmd inside {DAO_CMD_RD, DAO_CMD_WR}))
		else $error("rw in pd");
	a_rw_after_up: assert property (cmd inside {DAO_CMD_RD, DAO_CMD_WR} |-> $past(cke))
		else $error("rw at edge");
	a_ref_up: assert property (cmd == DAO_CMD_REF |-> cke) else $error("ref in pd");
	a_ref_gap: assert property (cmd == DAO_CMD_REF |=> (cmd == DAO_CMD_NOP) [*8]) else $error("ref gap");
	a_entry_quiet: assert property ($fell(cke) |-> cmd == DAO_CMD_NOP && $past(cmd) == DAO_CMD_NOP)
		else $error("entry cmd");
	a_pd_min_low: assert property ($fell(cke) |-> !cke [*2]) else $error("short pd");
	a_exit_quiet: assert property ($rose(cke) |-> (cmd == DAO_CMD_NOP) [*4]) else $error("exit cmd");
	// Re-entry right after exit still needs the WL-1 lead, so five high cycles at least
	a_up_min_high: assert property ($rose(cke) |-> cke [*5]) else $error("short up");
	c_odt_pd: cover property (!cke && odt);
endmodule
`default_nettype wire

// [sim/tb.sv]
// Bench joining controller end and memory end over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dao_pkg::*;
	localparam int WL   = 5;
	localparam int TRFC = 12;
	localparam int TXP  = 3;
	// Long tCPDED so a short stay makes the windows overlap
	localparam int TCD  = 4;
	logic     clk       = 1'b0;
	logic     rst_n     = 1'b0;
	logic     mr0       = 1'b0;
	logic     pd_req    = 1'b0;
	logic     cmd_valid = 1'b0;
	logic     odt_req   = 1'b0;
	dao_cmd_t cmd_code  = DAO_CMD_NOP;
	logic     cmd_ready, cmd_reject, c_pd, entry_win, exit_win, rtt_unc, unc_q;
	logic     rtt_on, async_mode, d_pd, rw_err;
	int       num_errors = 0;
	int       n_tests    = 0;
	int       cyc        = 0;
	int       n_ent      = 0;
	int       n_ext      = 0;
	int       n_rise     = 0;
	dao_link_if link();
	dao_ctrl_end #(.TRFC_CYC(TRFC), .TXPDLL_CYC(TXP), .TCPDED_CYC(TCD)) u_dao_ctrl_end (.clk(clk), .rst_n(rst_n),
		.wl(5'h5), .mr0_pd_dll(mr0), .pd_req(pd_req), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.odt_req(odt_req), .link(link.ctrl), .cmd_ready(cmd_ready), .cmd_reject(cmd_reject), .in_pd(c_pd),
		.entry_win(entry_win), .exit_win(exit_win), .rtt_uncertain(rtt_unc));
	dao_dram_end #(.TXPDLL_CYC(TXP)) u_dao_dram_end (.clk(clk), .rst_n(rst_n), .wl(5'h5), .mr0_pd_dll(mr0),
		.link(link.dram), .rtt_on(rtt_on), .async_mode(async_mode), .in_pd(d_pd), .rw_in_pd_err(rw_err));
	dao_checker u_dao_checker (.clk(clk), .rst_n(rst_n), .cke(link.cke), .odt(link.odt), .cmd(link.cmd));
	always #2 clk = ~clk;
	task automatic conclude;
		if (num_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		unc_q <= rtt_unc;
		n_ent <= n_ent + int'(entry_win);
		n_ext <= n_ext + int'(exit_win);
		n_rise <= n_rise + int'(rtt_unc && !unc_q);
		if (rst_n && rtt_unc !== (entry_win | exit_win)) chk(1'b0, "uncertain flag");
		if (cyc == 3000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic lat(input logic v, output int n);
		odt_req = v;
		tick();
		n = 0;
		while (rtt_on !== v && n < 20) begin
			tick();
			n++;
		end
	endtask
	task automatic wait_up;
		for (int i = 0; i < 80 && cmd_ready !== 1'b1; i++) tick();
	endtask
	task automatic wait_pd;
		for (int i = 0; i < 40 && c_pd !== 1'b1; i++) tick();
	endtask
	task automatic t_sync;
		int n;
		lat(1'b1, n);
		chk(n == WL - 2, "sync on latency");
		lat(1'b0, n);
		chk(n == WL - 2, "sync off latency");
	endtask
	task automatic t_pd(input logic mv);
		int   n;
		int   e0;
		int   x0;
		logic rj;
		mr0 = mv;
		e0 = n_ent;
		x0 = n_ext;
		pd_req = 1'b1;
		wait_pd();
		lat(1'b1, n);
		chk(n == (mv ? WL - 2 : 1) && async_mode === !mv && d_pd === 1'b1, "pd odt mode");
		rj = 1'b0;
		cmd_code = DAO_CMD_RD;
		cmd_valid = 1'b1;
		repeat (3) begin
			tick();
			rj |= cmd_reject;
			chk(link.cmd === DAO_CMD_NOP && rw_err === 1'b0, "rw in pd");
		end
		cmd_valid = 1'b0;
		chk(rj, "no reject");
		lat(1'b0, n);
		chk(n == (mv ? WL - 2 : 1), "pd odt off latency");
		pd_req = 1'b0;
		wait_up();
		chk(n_ent - e0 == (mv ? 0 : WL - 2 + TCD), "entry span");
		chk(n_ext - x0 == (mv ? 0 : WL - 2 + TXP + 1), "exit span");
		t_sync();
	endtask
	task automatic t_ref;
		int k0;
		mr0 = 1'b0;
		cmd_code = DAO_CMD_WR;
		cmd_valid = 1'b1;
		tick();
		chk(link.cmd === DAO_CMD_WR, "write issue");
		cmd_code = DAO_CMD_REF;
		tick();
		k0 = cyc;
		chk(link.cmd === DAO_CMD_REF && cmd_ready === 1'b0, "ref issue");
		cmd_valid = 1'b0;
		pd_req = 1'b1;
		for (int i = 0; i < 40 && !(c_pd === 1'b1 && entry_win === 1'b0); i++) tick();
		chk((cyc - 1 - k0) inside {TRFC - 1, TRFC}, "ref stretch");
		pd_req = 1'b0;
		wait_up();
	endtask
	task automatic t_short;
		int r0;
		mr0 = 1'b0;
		r0 = n_rise;
		pd_req = 1'b1;
		wait_pd();
		pd_req = 1'b0;
		wait_up();
		tick();
		chk(n_rise - r0 == 1, "overlap gap");
	endtask
	// Exit straight into a new entry: exit tail and next entry lead overlap
	task automatic t_idle;
		int r0;
		int e0;
		r0 = n_rise;
		e0 = n_ent;
		pd_req = 1'b1;
		wait_pd();
		pd_req = 1'b0;
		tick();
		pd_req = 1'b1;
		for (int i = 0; i < 40 && c_pd !== 1'b0; i++) tick();
		wait_pd();
		pd_req = 1'b0;
		wait_up();
		tick();
		chk(n_rise - r0 == 1, "idle gap");
		chk(n_ent - e0 == 2 * (WL - 2 + TCD), "idle entry span");
	endtask
	initial begin
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		tick();
		tick();
		t_sync();
		t_pd(1'b0);
		t_pd(1'b1);
		t_ref();
		t_short();
		t_idle();
		conclude();
	end
endmodule
`default_nettype wire
